//--- logic/tcic_timer.sv
// 16-bit up/down timer with input capture, 8-bit register port
// assumes the timer tick enable comes from an outside clock select,
// and irq acknowledges come from the interrupt controller
//
// What this block does
// - shared high-byte register holds its value between low-byte writes
// - 3-bit clock select chooses tick; zero stops the counter
// - counter steps up, down or clears on each timer tick
// - low-byte read of counter latches its high byte for later read
// - high write goes to holding reg; low write loads all 16 bits
// - software counter write beats count or clear in same cycle
// - counter reachable by software whether or not it runs
// - 4-bit mode field split over control registers a and b
// - overflow flag set where mode says, can raise interrupt
// - qualifying trigger edge copies counter into capture register
// - capture flag set with copy; enabled flag requests interrupt
// - capture flag clears on service or writing one
// - capture low read first latches high byte into holding reg
// - capture register writable only in modes using it as top
// - comparator select switches trigger source; may cause capture
// - comparator trigger sampled and edge detected like the capture pin
// - edge detector idles only in capture-top modes; filter keeps sampling
// - filter output changes only after four agreeing samples
// - filter enable bit in control b; filter runs on system clock
// - one 8-bit holding register shared by all 16-bit registers
// - bottom is 0x0000, maximum is 0xffff
module tcic_timer
   import tcic_pkg::*;
(
   // clock and reset
   input  wire logic          clk,
   input  wire logic          reset,
   // register port
   input  wire tcic_bus_req_t bus,
   output logic [7:0]         rdata,
   // external events and tick
   input  wire tcic_ext_in_t  ext,
   // status out
   output logic [2:0]         clock_select_field,
   output logic               irq_overflow,
   output logic               irq_capture,
   output logic               at_bottom,
   output logic               at_top
);
   typedef struct packed {
      logic [7:0]  timer_control_a;
      logic [7:0]  timer_control_b;
      logic [7:0]  comparator_ctrl_status;
      logic [7:0]  irq_mask;
      logic [7:0]  hold;
      logic [15:0] count_value;
      logic [15:0] capture_value;
      logic        overflow_flag;
      logic        capture_flag;
      logic        down;
      logic [7:0]  rdata;
   } tcic_state_t;

   tcic_state_t st, next_st;
   logic        cap_pin_edge;
   logic        cap_cmp_edge;
   logic [3:0]  waveform_mode_field;
   logic [15:0] top_val;
   logic        cap_top;
   logic        tick_en;

   // ===========================================================
   // mode decode
   assign waveform_mode_field = {
      st.timer_control_b[tcic_b_wgm_hi_lsb+1:tcic_b_wgm_hi_lsb],
      st.timer_control_a[tcic_b_wgm_lo_msb:0]};
   assign clock_select_field = st.timer_control_b[tcic_b_cs_msb:0];
   assign cap_top = tcic_mode_uses_cap(waveform_mode_field);
   // outside select turns the chosen source into a tick enable
   assign tick_en = ext.tick
                    && (clock_select_field != tcic_cs_off);
   assign top_val = cap_top ? st.capture_value : tcic_max;

   // ===========================================================
   // trigger paths: both conditioned alike so switching is clean
   tcic_trigger u_pin (
      .clk           (clk),
      .reset         (reset),
      .raw_in        (ext.capture_pin),
      .filter_enable (st.timer_control_b[tcic_b_filter]),
      .rising        (st.timer_control_b[tcic_b_edge]),
      .active        (!cap_top),
      .edge_pulse    (cap_pin_edge)
   );

   tcic_trigger u_cmp (
      .clk           (clk),
      .reset         (reset),
      .raw_in        (ext.comparator_output),
      .filter_enable (st.timer_control_b[tcic_b_filter]),
      .rising        (st.timer_control_b[tcic_b_edge]),
      .active        (!cap_top),
      .edge_pulse    (cap_cmp_edge)
   );

   // ===========================================================
   // next state
   always_comb begin
      logic trig;
      logic sel_cmp;
      logic [15:0] nxt_cnt;
      logic set_ovf;
      trig = 1'b0;
      sel_cmp = st.comparator_ctrl_status[tcic_b_comp_sel];
      nxt_cnt = st.count_value;
      set_ovf = 1'b0;
      next_st = st;
      next_st.rdata = tcic_rst_byte;

      // counting: dual-slope turns at top and bottom
      if (tick_en) begin
         if (waveform_mode_field == tcic_wgm_ctc_a
             || waveform_mode_field == tcic_wgm_cap_c
             || waveform_mode_field == tcic_wgm_cap_d) begin
            if (st.count_value == top_val) begin
               nxt_cnt = tcic_bottom;
               set_ovf = cap_top;
            end else
               nxt_cnt = st.count_value + tcic_one;
         end else if (cap_top) begin
            if (st.down) begin
               if (st.count_value == tcic_bottom) begin
                  next_st.down = 1'b0;
                  nxt_cnt = st.count_value + tcic_one;
                  set_ovf = 1'b1;
               end else
                  nxt_cnt = st.count_value - tcic_one;
            end else if (st.count_value == top_val) begin
               next_st.down = 1'b1;
               nxt_cnt = st.count_value - tcic_one;
            end else
               nxt_cnt = st.count_value + tcic_one;
         end else begin
            nxt_cnt = st.count_value + tcic_one;
            set_ovf = (st.count_value == tcic_max);
         end
      end
      next_st.count_value = nxt_cnt;

      // capture
      trig = sel_cmp ? cap_cmp_edge : cap_pin_edge;
      if (trig && !cap_top) begin
         next_st.capture_value = st.count_value;
      end

      // flag clears first, hardware sets win below
      if (ext.irq_ack_capture)
         next_st.capture_flag = 1'b0;
      if (ext.irq_ack_overflow)
         next_st.overflow_flag = 1'b0;

      // reads
      if (bus.rd) begin
         unique case (bus.addr)
            tcic_adr_ctrl_a:    next_st.rdata = st.timer_control_a;
            tcic_adr_ctrl_b:    next_st.rdata = st.timer_control_b;
            tcic_adr_cnt_lo: begin
               next_st.rdata = st.count_value[7:0];
               next_st.hold = st.count_value[15:8];
            end
            tcic_adr_cap_lo: begin
               next_st.rdata = st.capture_value[7:0];
               next_st.hold = st.capture_value[15:8];
            end
            tcic_adr_cnt_hi,
            tcic_adr_cap_hi:    next_st.rdata = st.hold;
            tcic_adr_flags: begin
               next_st.rdata[tcic_b_ovf] = st.overflow_flag;
               next_st.rdata[tcic_b_cap] = st.capture_flag;
            end
            tcic_adr_irq_mask:  next_st.rdata = st.irq_mask;
            tcic_adr_comp_ctrl: next_st.rdata = st.comparator_ctrl_status;
            default:            next_st.rdata = tcic_rst_byte;
         endcase
      end

      // writes
      if (bus.wr) begin
         unique case (bus.addr)
            tcic_adr_ctrl_a:    next_st.timer_control_a = bus.wdata;
            tcic_adr_ctrl_b:    next_st.timer_control_b = bus.wdata;
            tcic_adr_cnt_hi,
            tcic_adr_cap_hi:    next_st.hold = bus.wdata;
            tcic_adr_cnt_lo: begin
               // write wins over any count this cycle, running or not
               next_st.count_value = {st.hold, bus.wdata};
               set_ovf = 1'b0;
               next_st.down = st.down;
            end
            tcic_adr_cap_lo: begin
               if (cap_top)
                  next_st.capture_value = {st.hold, bus.wdata};
            end
            tcic_adr_flags: begin
               if (bus.wdata[tcic_b_ovf])
                  next_st.overflow_flag = 1'b0;
               if (bus.wdata[tcic_b_cap])
                  next_st.capture_flag = 1'b0;
            end
            tcic_adr_irq_mask:  next_st.irq_mask = bus.wdata;
            tcic_adr_comp_ctrl: next_st.comparator_ctrl_status = bus.wdata;
            default: ;
         endcase
      end
      // hold untouched by low writes so a shared high byte is reused

      if (set_ovf)
         next_st.overflow_flag = 1'b1;
      if (trig && !cap_top)
         next_st.capture_flag = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   // ===========================================================
   // outputs
   assign rdata = st.rdata;
   assign irq_overflow = st.overflow_flag && st.irq_mask[tcic_b_ovf];
   assign irq_capture = st.capture_flag
                        && st.irq_mask[tcic_b_cap];
   assign at_bottom = (st.count_value == tcic_bottom);
   assign at_top = (st.count_value == top_val);
endmodule : tcic_timer

//--- common/tcic_pkg.sv
// package for the 16-bit timer with input capture unit
// assumes an 8-bit register port and one 50 MHz system clock
package tcic_pkg;
   // ===========================================================
   // register offsets on the 8-bit port
   localparam logic [3:0] tcic_adr_ctrl_a    = 4'h0;
   localparam logic [3:0] tcic_adr_ctrl_b    = 4'h1;
   localparam logic [3:0] tcic_adr_cnt_lo    = 4'h2;
   localparam logic [3:0] tcic_adr_cnt_hi    = 4'h3;
   localparam logic [3:0] tcic_adr_cap_lo    = 4'h4;
   localparam logic [3:0] tcic_adr_cap_hi    = 4'h5;
   localparam logic [3:0] tcic_adr_flags     = 4'h6;
   localparam logic [3:0] tcic_adr_irq_mask  = 4'h7;
   localparam logic [3:0] tcic_adr_comp_ctrl = 4'h8;

   // ===========================================================
   // field positions
   localparam int tcic_b_wgm_lo_msb  = 1;   // ctrl_a[1:0] = mode[1:0]
   localparam int tcic_b_cs_msb      = 2;   // ctrl_b[2:0]
   localparam int tcic_b_wgm_hi_lsb  = 3;   // ctrl_b[4:3] = mode[3:2]
   localparam int tcic_b_edge        = 6;   // ctrl_b[6] 1 = rising
   localparam int tcic_b_filter      = 7;   // ctrl_b[7]
   localparam int tcic_b_ovf         = 0;   // flags / mask bit 0
   localparam int tcic_b_cap         = 5;   // flags / mask bit 5
   localparam int tcic_b_comp_sel    = 2;   // comp_ctrl[2]

   // ===========================================================
   // values
   localparam logic [15:0] tcic_bottom   = 16'h0000;
   localparam logic [15:0] tcic_max      = 16'hffff;
   localparam logic [15:0] tcic_one      = 16'h0001;
   localparam logic [2:0]  tcic_cs_off   = 3'h0;
   localparam logic [7:0]  tcic_rst_byte = 8'h00;
   localparam int          tcic_filt_len = 4;
   // modes; all but the last take top from the capture register
   localparam logic [3:0]  tcic_wgm_cap_a = 4'h8;
   localparam logic [3:0]  tcic_wgm_cap_b = 4'ha;
   localparam logic [3:0]  tcic_wgm_cap_c = 4'hc;
   localparam logic [3:0]  tcic_wgm_cap_d = 4'he;
   localparam logic [3:0]  tcic_wgm_ctc_a = 4'h4;

   // ===========================================================
   // carriers
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tcic_bus_req_t;

   typedef struct packed {
      logic       tick;      // timer clock enable from the prescaler
      logic       capture_pin;
      logic       comparator_output;
      logic       irq_ack_overflow;
      logic       irq_ack_capture;
   } tcic_ext_in_t;

   // ===========================================================
   // decoding shared by top and trigger edge detect
   function automatic logic tcic_mode_uses_cap(input logic [3:0] m);
      return (m == tcic_wgm_cap_a) || (m == tcic_wgm_cap_b) ||
             (m == tcic_wgm_cap_c) || (m == tcic_wgm_cap_d);
   endfunction : tcic_mode_uses_cap
endpackage : tcic_pkg

//--- logic/tcic_trigger.sv
// trigger conditioning: sync, optional 4-sample filter, edge detect
// assumes raw inputs are asynchronous to clk
module tcic_trigger
   import tcic_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // raw trigger and controls
   input  wire logic raw_in,
   input  wire logic filter_enable,
   input  wire logic rising,
   input  wire logic active,
   // event out
   output logic      edge_pulse
);
   typedef struct packed {
      logic       sync1;
      logic       sync2;
      // sync2 is the newest of the four samples, so the filter adds
      // exactly four cycles and not five
      logic [tcic_filt_len-2:0] hist;
      logic       filt;
      logic       last;
      logic       pulse;
   } tcic_trg_state_t;

   tcic_trg_state_t st, next_st;

   always_comb begin
      logic lvl;
      lvl = 1'b0;
      next_st = st;
      next_st.sync1 = raw_in;
      next_st.sync2 = st.sync1;
      next_st.hist = {st.hist[tcic_filt_len-3:0], st.sync2};
      // output moves only when all four samples agree
      if (&{st.hist, st.sync2})
         next_st.filt = 1'b1;
      else if (~|{st.hist, st.sync2})
         next_st.filt = 1'b0;
      lvl = filter_enable ? st.filt : st.sync2;
      next_st.last = lvl;
      // frozen while mode takes top from capture register
      next_st.pulse = active && (rising ? (lvl && !st.last)
                                        : (!lvl && st.last));
      if (!active)
         next_st.last = st.last;
   end

   always_ff @(posedge clk) begin
      if (reset)
         st <= '0;
      else
         st <= next_st;
   end

   assign edge_pulse = st.pulse;
endmodule : tcic_trigger

//--- sim/tcic_cpu.sv
// cpu side model: byte-wide register master of the timer
// assumes one shared clock and a slave without wait states
module tcic_cpu
   import tcic_pkg::*;
(
   // clock
   input  wire logic       clk,
   // register port
   output tcic_bus_req_t   bus,
   input  wire logic [7:0] rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial bus = '0;
   // =====================================================
   // one-cycle strobes; write data inverted once released
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus <= '{a, ~d, 1'b0, 1'b0};
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      @(negedge clk) d = rdata;
   endtask : rd
   // high byte first on writes, low byte first on reads
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr(a + 4'h1, v[15:8]);
      wr(a, v[7:0]);
   endtask : wr16
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      rd(a, v[7:0]);
      rd(a + 4'h1, v[15:8]);
   endtask : rd16
endmodule : tcic_cpu

//--- sim/tcic_chk.sv
// port checker of the capture timer
// assumes a bind to every timer instance
module tcic_chk
   import tcic_pkg::*;
(
   // clock and reset
   input wire logic          clk,
   input wire logic          reset,
   // watched ports
   input wire tcic_bus_req_t bus,
   input wire logic [7:0]    rdata,
   input wire tcic_ext_in_t  ext,
   input wire logic [2:0]    clock_select_field,
   input wire logic          irq_overflow,
   input wire logic          irq_capture,
   input wire logic          at_bottom,
   input wire logic          at_top
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // =====================================================
   // quiet: 15 cycles outlast sync, filter and edge stages
   logic [3:0] quiet;
   logic [1:0] trig_d;
   logic       wr_flg;
   assign wr_flg = bus.wr && bus.addr == tcic_adr_flags;
   always_ff @(posedge clk) begin
      trig_d <= {ext.capture_pin, ext.comparator_output};
      if (reset || (bus.wr && !wr_flg) ||
          trig_d != {ext.capture_pin, ext.comparator_output})
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end
   sequence zero_hi_s;
      bus.wr && bus.addr == tcic_adr_cnt_hi && bus.wdata == 8'h00;
   endsequence
   stop_off_a: assert property (
      clock_select_field == tcic_cs_off && !bus.wr |=> $stable(at_bottom))
      else $error("count moved while stopped");
   cs_field_a: assert property (
      bus.wr && bus.addr == tcic_adr_ctrl_b |=>
      clock_select_field == $past(bus.wdata[tcic_b_cs_msb:0]))
      else $error("clock select not taken");
   cnt_write_a: assert property (
      zero_hi_s ##1 !bus.wr ##1 bus.wr && bus.addr == tcic_adr_cnt_lo
      |=> at_bottom == ($past(bus.wdata) == 8'h00))
      else $error("counter write not loaded");
   ovf_clear_a: assert property (
      wr_flg && bus.wdata[tcic_b_ovf] && !ext.tick && !$past(ext.tick)
      |=> !irq_overflow) else $error("overflow flag kept");
   ovf_mask_a: assert property (
      bus.wr && bus.addr == tcic_adr_irq_mask && !bus.wdata[tcic_b_ovf]
      |=> !irq_overflow) else $error("overflow irq unmasked");
   cap_mask_a: assert property (
      bus.wr && bus.addr == tcic_adr_irq_mask && !bus.wdata[tcic_b_cap]
      |=> !irq_capture) else $error("capture irq unmasked");
   cap_quiet_a: assert property (
      quiet == 4'hf && !bus.wr && !irq_capture |=> !irq_capture)
      else $error("capture without edge");
   cap_clear_a: assert property (
      quiet == 4'hf &&
      (ext.irq_ack_capture || wr_flg && bus.wdata[tcic_b_cap])
      |=> !irq_capture) else $error("capture flag kept");
   cover property (irq_capture);
   cover property ($rose(irq_overflow));
   cover property (zero_hi_s);
endmodule : tcic_chk

bind tcic_timer tcic_chk tcic_chk_i (.clk, .reset, .bus, .rdata, .ext,
   .clock_select_field, .irq_overflow, .irq_capture, .at_bottom, .at_top);

//--- sim/testbench.sv
// testbench of the capture timer: cpu model on the bus, pins here
// assumes package, design, cpu model and checker compiled first
module testbench
   import tcic_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic          clk, reset, irq_overflow, irq_capture, at_bottom, at_top;
   logic [7:0]    rdata;
   logic [2:0]    clock_select_field;
   tcic_bus_req_t bus;
   tcic_ext_in_t  ext;
   int            num_errors, samples_checked;
   tcic_timer tcic_timer_i (.clk, .reset, .bus, .rdata, .ext,
      .clock_select_field, .irq_overflow, .irq_capture, .at_bottom, .at_top);
   tcic_cpu tcic_cpu_i (.clk, .bus, .rdata);
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // =====================================================
   // helpers
   task automatic chk(input string s, input logic [15:0] e, g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // latency counted in negedges from the pin edge
   task automatic wait_cap(output int n);
      for (n = 0; n < 40 && irq_capture !== 1'b1; n++)
         @(negedge clk);
      if (irq_capture !== 1'b1) begin
         chk("capture wait", 16'h1, 16'h0);
         end_sim();
      end
   endtask : wait_cap
   task automatic ticks(input int k);
      @(posedge clk) ext.tick <= 1'b1;
      repeat (k) @(posedge clk);
      ext.tick <= 1'b0;
   endtask : ticks
   task automatic pin(input logic p);
      @(posedge clk) ext.capture_pin <= p;
   endtask : pin
   // =====================================================
   // scenarios
   task automatic s_count;
      logic [15:0] v;
      tcic_cpu_i.wr16(tcic_adr_cnt_lo, 16'hfffd);
      ticks(3);
      tcic_cpu_i.wr(tcic_adr_irq_mask, 8'h21);
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h01);
      ticks(4);
      tcic_cpu_i.rd16(tcic_adr_cnt_lo, v);
      chk("wrap count", 16'h0001, v);
      chk("ovf irq", 16'h1, irq_overflow);
      tcic_cpu_i.wr(tcic_adr_flags, 8'h01);
      @(posedge clk) ext.tick <= 1'b1;
      tcic_cpu_i.wr16(tcic_adr_cnt_lo, 16'h0000);
      ext.tick <= 1'b0;
      tcic_cpu_i.rd16(tcic_adr_cnt_lo, v);
      chk("write wins", 16'h0000, v);
      chk("ovf cleared", 16'h0, irq_overflow);
   endtask : s_count
   task automatic s_top;
      logic [15:0] v;
      tcic_cpu_i.wr(tcic_adr_ctrl_a, 8'h02);
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h19);
      tcic_cpu_i.wr(tcic_adr_cap_hi, 8'h02);
      tcic_cpu_i.wr(tcic_adr_cap_lo, 8'h03);
      tcic_cpu_i.wr(tcic_adr_cnt_lo, 8'h01);
      ticks(2);
      @(negedge clk) chk("at top", 16'h1, at_top);
      ticks(2);
      tcic_cpu_i.rd16(tcic_adr_cnt_lo, v);
      chk("clear at top", 16'h0001, v);
      chk("top ovf", 16'h1, irq_overflow);
      @(posedge clk) ext.irq_ack_overflow <= 1'b1;
      @(posedge clk) ext.irq_ack_overflow <= 1'b0;
      @(negedge clk) chk("ovf ack", 16'h0, irq_overflow);
      tcic_cpu_i.rd16(tcic_adr_cap_lo, v);
      chk("cap top", 16'h0203, v);
      pin(1'b1);
      repeat (12) @(posedge clk);
      pin(1'b0);
      repeat (12) @(negedge clk);
      chk("frozen", 16'h0, irq_capture);
      tcic_cpu_i.wr(tcic_adr_flags, 8'h01);
      // mode b: dual slope, turns down at the capture top
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h11);
      tcic_cpu_i.wr16(tcic_adr_cnt_lo, 16'h0202);
      ticks(3);
      tcic_cpu_i.rd16(tcic_adr_cnt_lo, v);
      chk("dual slope", 16'h0201, v);
   endtask : s_top
   task automatic s_capture;
      logic [15:0] v;
      int          l0, l1;
      // mode 0xd: no capture top, differs from c only in control a
      tcic_cpu_i.wr(tcic_adr_ctrl_a, 8'h01);
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h58);
      tcic_cpu_i.wr16(tcic_adr_cap_lo, 16'h1111);
      tcic_cpu_i.rd16(tcic_adr_cap_lo, v);
      chk("cap locked", 16'h0203, v);
      tcic_cpu_i.wr16(tcic_adr_cnt_lo, 16'h5a3c);
      pin(1'b1);
      wait_cap(l0);
      tcic_cpu_i.rd16(tcic_adr_cap_lo, v);
      chk("cap rise", 16'h5a3c, v);
      @(posedge clk) ext.irq_ack_capture <= 1'b1;
      @(posedge clk) ext.irq_ack_capture <= 1'b0;
      @(negedge clk) chk("ack clear", 16'h0, irq_capture);
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h80);
      tcic_cpu_i.wr16(tcic_adr_cnt_lo, 16'h0777);
      pin(1'b0);
      repeat (3) @(posedge clk);
      ext.capture_pin <= 1'b1;
      repeat (16) @(negedge clk);
      chk("glitch", 16'h0, irq_capture);
      pin(1'b0);
      wait_cap(l1);
      tcic_cpu_i.rd16(tcic_adr_cap_lo, v);
      chk("cap fall", 16'h0777, v);
      chk("filter delay", 16'(l0 + 4), 16'(l1));
      tcic_cpu_i.wr(tcic_adr_flags, 8'h20);
      @(negedge clk) chk("write one", 16'h0, irq_capture);
   endtask : s_capture
   task automatic s_comp;
      int n;
      tcic_cpu_i.wr(tcic_adr_ctrl_b, 8'h40);
      tcic_cpu_i.wr(tcic_adr_comp_ctrl, 8'h04);
      repeat (16) @(posedge clk);
      tcic_cpu_i.wr(tcic_adr_flags, 8'h20);
      pin(1'b1);
      repeat (12) @(negedge clk);
      chk("pin ignored", 16'h0, irq_capture);
      @(posedge clk) ext.comparator_output <= 1'b1;
      wait_cap(n);
      tcic_cpu_i.wr(tcic_adr_irq_mask, 8'h00);
      @(negedge clk) chk("cap masked", 16'h0, irq_capture);
   endtask : s_comp
   initial begin
      num_errors = 0;
      samples_checked = 0;
      reset = 1'b1;
      ext = '0;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk) chk("bottom", 16'h1, at_bottom);
      s_count();
      s_top();
      s_capture();
      s_comp();
      end_sim();
   end
endmodule : testbench
